/* File: cisup_pkg.sv */
/*
  package for the configuration integrity supervisor: states, timing
  constants and the carrier structs shared by the design.
  assumes a single 25 MHz system clock.
*/
`default_nettype none

package cisup_pkg;

  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CASC_PULSE_MS = 250;
  localparam int unsigned CASC_PULSE_CYC = (CLK_HZ / 1000) * CASC_PULSE_MS;
  localparam int unsigned WDOG_MS = 100;
  localparam int unsigned WDOG_CYC = (CLK_HZ / 1000) * WDOG_MS;
  localparam int unsigned RST_HOLD_CYC = 16;

  // --------------------------------------------------------------
  // sizes
  // --------------------------------------------------------------
  localparam int unsigned CFG_WORDS = 16;
  localparam int unsigned CFG_AW = 4;
  localparam int unsigned LOG_ENTRIES = 8;
  localparam int unsigned LOG_AW = 3;
  localparam int unsigned DW = 16;
  localparam int unsigned CKW = 8;

  // --------------------------------------------------------------
  // status bits
  // --------------------------------------------------------------
  localparam int unsigned ST_CFG_BAD = 0;
  localparam int unsigned ST_FW_BAD = 1;
  localparam int unsigned ST_WDOG = 2;
  localparam int unsigned ST_PARAM_BAD = 3;
  localparam int unsigned ST_RESTAGE = 4;
  localparam int unsigned ST_READY = 5;
  localparam int unsigned STW = 8;

  localparam logic [DW-1:0] PARAM_MIN = 16'h0000;
  localparam logic [DW-1:0] PARAM_MAX = 16'h7FFF;
  localparam logic [DW-1:0] CFG_ERASED = 16'h0000;

  typedef enum logic [2:0] {
    CISUP_RESET   = 3'b000,
    CISUP_FW      = 3'b001,
    CISUP_CFG     = 3'b010,
    CISUP_LOG     = 3'b011,
    CISUP_RUN     = 3'b100,
    CISUP_FWFAIL  = 3'b101
  } cisup_state_type;

  // management bus write of one working parameter
  typedef struct packed {
    logic valid;
    logic pin_func;
    logic [CFG_AW-1:0] addr;
    logic [DW-1:0] data;
  } cisup_wr_type;

  // fault log entry as stored in nonvolatile storage
  typedef struct packed {
    logic [DW-1:0] data;
    logic [CKW-1:0] sum;
  } cisup_log_type;

endpackage

`default_nettype wire

/* File: cisup_top.sv */
/*
  configuration integrity supervisor: power-up checksum sequence over
  firmware, configuration and fault log, firmware watchdog, cascade
  clock fail pulses, alert output and staged configuration updates.
  assumes the nonvolatile images are presented combinationally by an
  external store indexed by the address outputs, all on clk_in.
*/
`default_nettype none

module cisup_top
  import cisup_pkg::*;
#(
  parameter int unsigned WDOG_CYCLES = WDOG_CYC,
  parameter int unsigned PULSE_CYCLES = CASC_PULSE_CYC
) (
  input wire logic clk_in,                 // system clock, 25 MHz
  input wire logic arst_n_in,              // async reset, active low
  input wire logic [CKW-1:0] fw_sum_in,    // computed firmware checksum
  input wire logic [CKW-1:0] fw_ref_in,    // stored firmware checksum
  input wire logic [DW-1:0] nv_cfg_in,     // nv config word at cfg addr
  input wire logic [CKW-1:0] nv_cfg_ref_in, // stored config checksum
  input wire cisup_log_type nv_log_in,     // nv log entry at log addr
  input wire logic wdog_kick_in,           // firmware watchdog service
  input wire cisup_wr_type bus_wr_in,      // management bus write
  input wire logic [CFG_AW-1:0] rd_addr_in, // working config read addr
  input wire logic tck_in,                 // scan clock pin
  input wire logic tms_in,                 // scan mode select pin
  input wire logic tdi_in,                 // scan data in pin
  output logic tdo_out,                    // scan data out
  output logic [CFG_AW-1:0] nv_cfg_addr_out, // nv config fetch address
  output logic [LOG_AW-1:0] nv_log_addr_out, // nv log fetch address
  output logic [DW-1:0] rd_data_out,       // working config read data
  output logic [LOG_ENTRIES-1:0] log_valid_out, // kept log entries
  output logic [STW-1:0] status_out,       // status flags
  output logic host_alert_output_n_out,    // alert, active low, od
  output logic host_alert_oe_out,          // alert pin output enable
  output logic casc_clk_out,               // cascade clock pin level
  output logic casc_clk_oe_out,            // cascade clock enable
  output logic pins_oe_out,                // global io enable
  output logic param_reject_out            // bus write refused
);

  // ------------------------------------------------------------
  // input synchronisers for the scan pins
  // ------------------------------------------------------------
  logic [2:0] scan_s1, scan_s2;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scan_s1 <= 3'h0;
      scan_s2 <= 3'h0;
    end else begin
      scan_s1 <= {tck_in, tms_in, tdi_in};
      scan_s2 <= scan_s1;
    end
  end

  // ------------------------------------------------------------
  // internal reset: watchdog or firmware mismatch restart
  // ------------------------------------------------------------
  cisup_state_type state, next_state;
  logic [$clog2(RST_HOLD_CYC+1)-1:0] hold_cnt;
  logic [$clog2(WDOG_CYCLES+1)-1:0] wdog_cnt;
  logic wdog_expire, fw_mismatch, soft_rst;

  assign wdog_expire = (state == CISUP_RUN) &&
    (wdog_cnt == $bits(wdog_cnt)'(WDOG_CYCLES - 1));
  assign fw_mismatch = (state == CISUP_FW) && (fw_sum_in != fw_ref_in);
  assign soft_rst = wdog_expire;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      wdog_cnt <= '0;
    else if (state != CISUP_RUN || wdog_kick_in)
      wdog_cnt <= '0;
    else
      wdog_cnt <= wdog_cnt + 1'b1;
  end

  // ------------------------------------------------------------
  // power-up verification sequence
  // ------------------------------------------------------------
  logic [CFG_AW-1:0] cfg_idx;
  logic [LOG_AW-1:0] log_idx;
  logic [CKW-1:0] cfg_acc;
  logic cfg_last, log_last;
  logic [CKW-1:0] cfg_acc_final;

  assign cfg_last = cfg_idx == CFG_AW'(CFG_WORDS - 1);
  assign log_last = log_idx == LOG_AW'(LOG_ENTRIES - 1);
  assign cfg_acc_final = cfg_acc + nv_cfg_in[CKW-1:0] + nv_cfg_in[DW-1:CKW];

  always_comb begin
    next_state = state;
    unique case (state)
      CISUP_RESET:
        if (hold_cnt == '0) next_state = CISUP_FW;
      CISUP_FW:
        if (fw_mismatch) next_state = CISUP_FWFAIL;
        else next_state = CISUP_CFG;
      CISUP_CFG:
        if (cfg_last) next_state = CISUP_LOG;
      CISUP_LOG:
        if (log_last) next_state = CISUP_RUN;
      CISUP_RUN:
        if (soft_rst) next_state = CISUP_RESET;
      CISUP_FWFAIL:
        if (hold_cnt == '0) next_state = CISUP_RESET;
      default:
        next_state = CISUP_RESET;
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      state <= CISUP_RESET;
    else
      state <= next_state;
  end

  // hold counter: reset hold only; the cascade pulse width is timed by pulse_cnt
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      hold_cnt <= $bits(hold_cnt)'(RST_HOLD_CYC);
    else if (state != CISUP_RESET && next_state == CISUP_RESET)
      hold_cnt <= $bits(hold_cnt)'(RST_HOLD_CYC);
    else if (hold_cnt != '0)
      hold_cnt <= hold_cnt - 1'b1;
  end

  // ------------------------------------------------------------
  // cascade clock fail pulses
  // ------------------------------------------------------------
  logic [$clog2(PULSE_CYCLES+1)-1:0] pulse_cnt;
  logic pulse_done;
  assign pulse_done = pulse_cnt == '0;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      pulse_cnt <= '0;
    // a running pulse is not restarted, so the fail loop leaves gaps
    else if (fw_mismatch && pulse_done)
      pulse_cnt <= $bits(pulse_cnt)'(PULSE_CYCLES);
    else if (!pulse_done)
      pulse_cnt <= pulse_cnt - 1'b1;
  end

  // the pulse outlives the short reset; repeated failures repeat it
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      casc_clk_out <= 1'b0;
      casc_clk_oe_out <= 1'b0;
    end else begin
      casc_clk_out <= !pulse_done;
      casc_clk_oe_out <= !pulse_done;
    end
  end

  // ------------------------------------------------------------
  // configuration load and checksum
  // ------------------------------------------------------------
  logic [DW-1:0] work_cfg [CFG_WORDS];
  logic [CFG_WORDS-1:0] pin_pending;
  logic cfg_bad, cfg_bad_q;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_idx <= '0;
      cfg_acc <= '0;
    end else if (state == CISUP_CFG) begin
      cfg_idx <= cfg_idx + 1'b1;
      cfg_acc <= cfg_acc_final;
    end else begin
      cfg_idx <= '0;
      cfg_acc <= '0;
    end
  end

  assign cfg_bad = (state == CISUP_CFG) && cfg_last &&
    (cfg_acc_final != nv_cfg_ref_in);

  logic param_ok;
  assign param_ok = bus_wr_in.data >= PARAM_MIN &&
    bus_wr_in.data <= PARAM_MAX;

  // nv image is only copied at the verification pass
  always_ff @(posedge clk_in) begin
    if (state == CISUP_CFG)
      work_cfg[cfg_idx] <= nv_cfg_in;
    else if (state == CISUP_LOG && cfg_bad_q) begin
      for (int i = 0; i < CFG_WORDS; i++)
        work_cfg[i] <= CFG_ERASED;
    end else if (state == CISUP_RUN && bus_wr_in.valid && param_ok)
      work_cfg[bus_wr_in.addr] <= bus_wr_in.data;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      cfg_bad_q <= 1'b0;
    else if (state == CISUP_CFG)
      cfg_bad_q <= cfg_bad;
  end

  // pin-function words are flagged until the next reset reloads them
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      pin_pending <= '0;
    else if (state != CISUP_RUN)
      pin_pending <= '0;
    else if (bus_wr_in.valid && param_ok && bus_wr_in.pin_func)
      pin_pending[bus_wr_in.addr] <= 1'b1;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      param_reject_out <= 1'b0;
    else
      param_reject_out <= bus_wr_in.valid && !param_ok;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      rd_data_out <= '0;
    else
      rd_data_out <= work_cfg[rd_addr_in];
  end

  // ------------------------------------------------------------
  // fault log screening
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      log_idx <= '0;
    else if (state == CISUP_LOG)
      log_idx <= log_idx + 1'b1;
    else
      log_idx <= '0;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      log_valid_out <= '0;
    else if (state == CISUP_LOG)
      log_valid_out[log_idx] <= (nv_log_in.data[CKW-1:0] +
        nv_log_in.data[DW-1:CKW]) == nv_log_in.sum;
  end

  assign nv_cfg_addr_out = cfg_idx;
  assign nv_log_addr_out = log_idx;

  // ------------------------------------------------------------
  // status, alert and pin enables
  // ------------------------------------------------------------
  logic wdog_seen, fw_seen;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wdog_seen <= 1'b0;
      fw_seen <= 1'b0;
    end else begin
      if (wdog_expire) wdog_seen <= 1'b1;
      if (fw_mismatch) fw_seen <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      status_out <= '0;
      host_alert_output_n_out <= 1'b1;
      host_alert_oe_out <= 1'b0;
    end else begin
      status_out <= '0;
      status_out[ST_CFG_BAD] <= cfg_bad_q;
      status_out[ST_FW_BAD] <= fw_seen;
      status_out[ST_WDOG] <= wdog_seen;
      status_out[ST_PARAM_BAD] <= param_reject_out;
      status_out[ST_RESTAGE] <= |pin_pending;
      status_out[ST_READY] <= state == CISUP_RUN;
      host_alert_output_n_out <= !(cfg_bad_q && state == CISUP_RUN);
      host_alert_oe_out <= cfg_bad_q && state == CISUP_RUN;
    end
  end

  // ordinary reset: io released while not running
  assign pins_oe_out = state == CISUP_RUN;

  // ------------------------------------------------------------
  // boundary scan: bypass path only, no config access
  // ------------------------------------------------------------
  logic tck_q, bypass_bit;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tck_q <= 1'b0;
      bypass_bit <= 1'b0;
      tdo_out <= 1'b0;
    end else begin
      tck_q <= scan_s2[2];
      if (scan_s2[2] && !tck_q)
        bypass_bit <= scan_s2[1] ? 1'b0 : scan_s2[0];
      if (!scan_s2[2] && tck_q)
        tdo_out <= bypass_bit;   // scan never writes work_cfg
    end
  end

endmodule

`default_nettype wire

/* File: cisup_chk.sv */
/*
  assertions on the supervisor's top ports.
  assumes it is bound into cisup_top with the same count parameters.
*/
`default_nettype none
module cisup_chk
  import cisup_pkg::*;
#(
  parameter int unsigned WDOG_CYCLES = WDOG_CYC,
  parameter int unsigned PULSE_CYCLES = CASC_PULSE_CYC
) (
  input wire logic clk_in, // clock
  input wire logic arst_n_in, // reset
  input wire cisup_wr_type bus_wr_in, // bus write
  input wire logic [CFG_AW-1:0] rd_addr_in, // read address
  input wire logic wdog_kick_in, // kick
  input wire logic [DW-1:0] rd_data_out, // read data
  input wire logic [LOG_ENTRIES-1:0] log_valid_out, // kept log
  input wire logic [STW-1:0] status_out, // status
  input wire logic host_alert_output_n_out, // alert
  input wire logic host_alert_oe_out, // alert enable
  input wire logic casc_clk_out, // cascade clock
  input wire logic pins_oe_out, // io enable
  input wire logic param_reject_out // refusal
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);
  int casc_cnt;
  int wd_cnt;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      casc_cnt <= 0;
      wd_cnt <= 0;
    end else begin
      casc_cnt <= casc_clk_out ? casc_cnt + 1 : 0;
      // two cycles of slack cover where the kick is registered
      wd_cnt <= (pins_oe_out && !wdog_kick_in) ? wd_cnt + 1 : 0;
    end
  end
  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  sequence s_good_wr;
    bus_wr_in.valid && !bus_wr_in.pin_func &&
      bus_wr_in.data <= PARAM_MAX && status_out[ST_READY];
  endsequence
  sequence s_same_rd;
    rd_addr_in == $past(bus_wr_in.addr) && !bus_wr_in.valid;
  endsequence
  property p_stored;
    s_good_wr ##1 s_same_rd |=> rd_data_out == $past(bus_wr_in.data, 2);
  endproperty
  property p_rej_cause;
    param_reject_out |-> $past(bus_wr_in.valid) &&
      $past(bus_wr_in.data) > PARAM_MAX;
  endproperty
  property p_rej_need;
    bus_wr_in.valid && bus_wr_in.data > PARAM_MAX && status_out[ST_READY]
      |=> param_reject_out;
  endproperty
  property p_alert;
    !host_alert_output_n_out |-> host_alert_oe_out &&
      status_out[ST_CFG_BAD];
  endproperty
  property p_casc_len;
    $fell(casc_clk_out) |-> casc_cnt == PULSE_CYCLES;
  endproperty
  property p_casc_fw;
    $rose(casc_clk_out) |-> !pins_oe_out ##[0:2] status_out[ST_FW_BAD];
  endproperty
  property p_wdog;
    pins_oe_out |-> wd_cnt <= WDOG_CYCLES + 2;
  endproperty
  property p_log;
    status_out[ST_READY] && $past(status_out[ST_READY])
      |-> $stable(log_valid_out);
  endproperty
  a_stored: assert property (p_stored)
    else $error("write not applied");
  a_rej_cause: assert property (p_rej_cause)
    else $error("refusal without cause");
  a_rej_need: assert property (p_rej_need)
    else $error("out of range accepted");
  a_alert: assert property (p_alert)
    else $error("alert without flag");
  a_casc_len: assert property (p_casc_len)
    else $error("cascade pulse width");
  a_casc_fw: assert property (p_casc_fw)
    else $error("cascade pulse while running");
  a_wdog: assert property (p_wdog)
    else $error("watchdog did not reset");
  a_log: assert property (p_log)
    else $error("log set changed while running");
endmodule
bind cisup_top cisup_chk #(
  .WDOG_CYCLES(WDOG_CYCLES),
  .PULSE_CYCLES(PULSE_CYCLES)
) u_chk (
  .clk_in, .arst_n_in, .bus_wr_in, .rd_addr_in, .wdog_kick_in,
  .rd_data_out, .log_valid_out, .status_out, .host_alert_output_n_out,
  .host_alert_oe_out, .casc_clk_out, .pins_oe_out, .param_reject_out
);
`default_nettype wire

/* File: cisup_nvstore.sv */
/*
  model of the nonvolatile store: config image, fault log, fw sums.
  assumes it is read combinationally through the address outputs.
*/
`default_nettype none
module cisup_nvstore
  import cisup_pkg::*;
(
  input wire logic [CFG_AW-1:0] cfg_addr_in, // config address
  input wire logic [LOG_AW-1:0] log_addr_in, // log address
  input wire logic gen_in, // image generation
  input wire logic cfg_bad_in, // spoil config sum
  input wire logic fw_bad_in, // spoil firmware sum
  input wire logic [LOG_ENTRIES-1:0] log_bad_in, // spoil entries
  output logic [DW-1:0] cfg_out, // config word
  output logic [CKW-1:0] cfg_ref_out, // config sum
  output cisup_log_type log_out, // log entry
  output logic [CKW-1:0] fw_sum_out, // computed fw sum
  output logic [CKW-1:0] fw_ref_out // stored fw sum
);
  function automatic logic [DW-1:0] word(input int i, input logic g);
    return 16'h0101 * 16'(i + 1) + (g ? 16'h0040 : 16'h0000);
  endfunction
  always_comb begin
    logic [DW-1:0] w;
    w = '0;
    cfg_ref_out = 8'h00;
    for (int i = 0; i < CFG_WORDS; i++) begin
      w = word(i, gen_in);
      cfg_ref_out = cfg_ref_out + w[7:0] + w[15:8];
    end
    cfg_ref_out = cfg_ref_out ^ {8{cfg_bad_in}};
    cfg_out = word(int'(cfg_addr_in), gen_in);
    log_out.data = 16'h0300 + 16'(log_addr_in) * 16'h0011;
    log_out.sum = (log_out.data[7:0] + log_out.data[15:8]) ^
      {8{log_bad_in[log_addr_in]}};
    fw_sum_out = 8'h5A;
    fw_ref_out = fw_bad_in ? 8'hA5 : 8'h5A;
  end
endmodule
`default_nettype wire

/* File: testbench.sv */
/*
  bench for cisup_top with the store model on its nonvolatile side.
  assumes shortened watchdog and pulse counts; scan pins held idle except in the scan test.
*/
`default_nettype none
module testbench import cisup_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WD = 50;
  localparam int PC = 20;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic wdog_kick_in = 1'b0;
  logic kick_en = 1'b1;
  logic gen = 1'b0;
  logic cfg_bad = 1'b0;
  logic fw_bad = 1'b0;
  cisup_wr_type bus_wr_in = '0;
  logic [CFG_AW-1:0] rd_addr_in = '0;
  logic [CFG_AW-1:0] ca;
  logic [LOG_AW-1:0] la;
  logic [DW-1:0] cw, rd_data;
  logic [CKW-1:0] cref, fsum, fref;
  cisup_log_type le;
  logic [LOG_ENTRIES-1:0] kept;
  logic [STW-1:0] st;
  logic alert_n, alert_oe, casc, casc_oe, pins_oe, reject, r, rs, tdo;
  logic tck = 1'b0;
  logic tms = 1'b1;
  logic tdi = 1'b0;
  int mismatches = 0;
  int comparisons = 0;
  int kc = 0;
  always #20 clk_in = ~clk_in;
  cisup_nvstore u_nv (
    .cfg_addr_in(ca), .log_addr_in(la), .gen_in(gen), .cfg_bad_in(cfg_bad),
    .fw_bad_in(fw_bad), .log_bad_in(8'h24), .cfg_out(cw), .cfg_ref_out(cref),
    .log_out(le), .fw_sum_out(fsum), .fw_ref_out(fref)
  );
  cisup_top #(.WDOG_CYCLES(WD), .PULSE_CYCLES(PC)) DUT (
    .clk_in, .arst_n_in, .fw_sum_in(fsum), .fw_ref_in(fref), .nv_cfg_in(cw),
    .nv_cfg_ref_in(cref), .nv_log_in(le), .wdog_kick_in, .bus_wr_in,
    .rd_addr_in, .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo),
    .nv_cfg_addr_out(ca), .nv_log_addr_out(la), .rd_data_out(rd_data),
    .log_valid_out(kept), .status_out(st), .host_alert_output_n_out(alert_n),
    .host_alert_oe_out(alert_oe), .casc_clk_out(casc),
    .casc_clk_oe_out(casc_oe), .pins_oe_out(pins_oe),
    .param_reject_out(reject)
  );
  // firmware service every 8 cycles while enabled
  always @(posedge clk_in) begin
    #2;
    wdog_kick_in = kick_en && (kc % 8 == 0);
    kc++;
  end
  function automatic logic [DW-1:0] word(input int i, input logic g);
    return 16'h0101 * 16'(i + 1) + (g ? 16'h0040 : 16'h0000);
  endfunction
  task automatic tick();
    @(posedge clk_in);
    #2;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic boot();
    int n;
    arst_n_in = 1'b0;
    repeat (4) tick();
    arst_n_in = 1'b1;
    n = 0;
    while (st[ST_READY] !== 1'b1 && n < 400) begin
      tick();
      n++;
    end
    chk(st[ST_READY], 1'b1);
  endtask
  task automatic wr(input logic pf, input logic [3:0] a, input logic [15:0] d);
    bus_wr_in = '{valid: 1'b1, pin_func: pf, addr: a, data: d};
    rd_addr_in = a;
    tick();
    bus_wr_in.valid = 1'b0;
    r = reject;
    tick();
    // the refusal flag stands in the status word for one cycle only
    rs = st[ST_PARAM_BAD];
    tick();
  endtask
  task automatic t_update();
    wr(1'b0, 4'h3, 16'h7FFF);
    chk(r, 1'b0);
    chk(rd_data, 16'h7FFF);
    wr(1'b0, 4'h5, 16'h8000);
    chk(r, 1'b1);
    chk(rd_data, word(5, 1'b0));
    chk(rs, 1'b1);
    wr(1'b1, 4'h6, 16'h0001);
    chk(st[ST_RESTAGE], 1'b1);
    gen = 1'b1;
    wr(1'b0, 4'h5, 16'h9000);
    chk(rd_data, word(5, 1'b0));
    boot();
    chk(st[ST_RESTAGE], 1'b0);
    wr(1'b0, 4'h5, 16'hFFFF);
    chk(rd_data, word(5, 1'b1));
    $display("test update done");
  endtask
  task automatic t_cfg_bad();
    cfg_bad = 1'b1;
    boot();
    chk({alert_n, alert_oe, st[ST_CFG_BAD]}, 3'b011);
    for (int i = 0; i < CFG_WORDS; i++) begin
      wr(1'b0, 4'(i), 16'hF000);
      chk(rd_data, CFG_ERASED);
    end
    cfg_bad = 1'b0;
    $display("test config fault done");
  endtask
  task automatic t_fw_bad();
    int rises;
    int runs;
    logic p;
    fw_bad = 1'b1;
    arst_n_in = 1'b0;
    tick();
    arst_n_in = 1'b1;
    rises = 0;
    runs = 0;
    p = 1'b0;
    repeat (200) begin
      tick();
      if (casc === 1'b1 && casc_oe === 1'b1 && p === 1'b0) rises++;
      if (pins_oe === 1'b1) runs++;
      p = casc;
    end
    chk(rises > 2, 1'b1);
    chk(runs, 0);
    chk(st[ST_FW_BAD], 1'b1);
    fw_bad = 1'b0;
    repeat (80) tick();
    chk({st[ST_READY], st[ST_FW_BAD], casc, casc_oe}, 4'b1100);
    $display("test firmware fault done");
  endtask
  task automatic t_wdog();
    int n;
    kick_en = 1'b0;
    n = 0;
    while (pins_oe === 1'b1 && n < WD + 20) begin
      tick();
      n++;
    end
    chk(n > WD - 10, 1'b1);
    // the seen flag reaches the status word one edge after the reset
    tick();
    chk({pins_oe, st[ST_WDOG]}, 2'b01);
    kick_en = 1'b1;
    repeat (60) tick();
    chk(st[ST_READY], 1'b1);
    $display("test watchdog done");
  endtask
  task automatic t_scan();
    rd_addr_in = 4'h0;
    tms = 1'b0;
    for (int i = 0; i < 2; i++) begin
      tdi = (i == 0);
      tck = 1'b1;
      repeat (4) tick();
      tck = 1'b0;
      repeat (4) tick();
      chk(tdo, tdi);
    end
    tms = 1'b1;
    chk(rd_data, word(0, 1'b1));
    $display("test scan done");
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    boot();
    chk({kept, alert_n, st[ST_CFG_BAD], pins_oe}, 11'h6DD);
    $display("test boot done");
    t_update();
    t_cfg_bad();
    t_fw_bad();
    t_wdog();
    t_scan();
    summarize();
  end
  initial begin
    #200000;
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
